// ==== hw/hbc_ctrl.sv ====
// bridge control and supply supervision: config, output steering, filters
// assumes a serial front end delivering whole 16-bit frames on SYS_CLK
`timescale 1ns/100ps
`default_nettype none
`include "hbc_regs.svh"

// Behaviour
// - active limit bit enables current regulation
// - limit bit clear: only flag overcurrent
// - outputs live only with wake high, shutoff low
// - enable bit clear: both outputs off
// - mode bit: full bridge or half bridges
// - source bit set: virtual inputs drive outputs
// - source bit clear: drive pins steer outputs
// - virtual input two mirrors pin two
// - virtual input one mirrors pin one
// - half bridge disables active current limit
// - half bridge: overvoltage flag only, shorts per output
// - half bridge: no open load check
// - filtered undervoltage switches all transistors off
// - undervoltage recovery needs filtered good supply
// - filtered overvoltage sets its status flag
// - full bridge overvoltage: both high sides on
// - overvoltage recovery restores normal control
// - overvoltage flag stays until cleared
// - write one clears flag unless fault persists
// - status bit nine undervoltage, eight overvoltage
// - protect-off mask bit makes overvoltage warning only
module hbc_ctrl #(
  parameter int UV_FILT_CYC = `HBC_UV_FILT_CYC,
  parameter int OV_FILT_CYC = `HBC_OV_FILT_CYC,
  parameter int OC_FILT_CYC = `HBC_OC_FILT_CYC,
  parameter int SC_FILT_CYC = `HBC_SC_FILT_CYC,
  parameter logic [12:0] ID_VALUE = 13'h0000 // arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic FRAME_STB,
  input wire logic [15:0] FRAME_WORD,
  output logic [15:0] RESP_WORD,
  input wire logic WAKE_PIN,
  input wire logic SHUTOFF_PIN,
  input wire logic DRIVE_PIN_ONE,
  input wire logic DRIVE_PIN_TWO,
  input wire logic SUPPLY_LOW_CMP,
  input wire logic SUPPLY_HIGH_CMP,
  input wire logic CURRENT_OVER_CMP,
  input wire logic [1:0] SHORT_CMP,
  output hbc_pkg::hbc_gate_t BRIDGE_OUTPUT_ONE,
  output hbc_pkg::hbc_gate_t BRIDGE_OUTPUT_TWO,
  output logic CURRENT_REG_ACTIVE,
  output logic [1:0] CURRENT_THRESHOLD_SEL,
  output logic [2:0] SLEW_SEL,
  output logic OPEN_LOAD_CHK_EN,
  output logic FAULT_STATUS_PIN_N
);

  localparam int NCH = 5;
  localparam logic [10:0] FILT_LIM [NCH] = '{11'(UV_FILT_CYC), 11'(OV_FILT_CYC),
    11'(OC_FILT_CYC), 11'(SC_FILT_CYC), 11'(SC_FILT_CYC)};

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [8:0] raw;
  logic [8:0] s1_q;
  logic [8:0] s2_q;
  assign raw = {SHORT_CMP, CURRENT_OVER_CMP, SUPPLY_HIGH_CMP, SUPPLY_LOW_CMP,
    DRIVE_PIN_TWO, DRIVE_PIN_ONE, SHUTOFF_PIN, WAKE_PIN};
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic wake_s;
  logic shutoff_s;
  logic pin1_s;
  logic pin2_s;
  logic [NCH-1:0] cmp;
  assign wake_s = s2_q[0];
  assign shutoff_s = s2_q[1];
  assign pin1_s = s2_q[2];
  assign pin2_s = s2_q[3];
  assign cmp = s2_q[8:4];

  // ----------------------------------------
  // comparator filters: uv ov oc sc1 sc2
  // ----------------------------------------
  logic [NCH-1:0] flt;
  for (genvar g = 0; g < NCH; g++)
  begin : g_filt
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic fq;
    logic fd;
    always_comb
    begin
      fd = fq;
      cnt_d = 11'h000;
      if (cmp[g] != fq)
      begin
        if (cnt_q >= FILT_LIM[g] - 11'h001)
          fd = cmp[g];
        else
          cnt_d = cnt_q + 11'h001;
      end
    end
    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
      if (!RSTN)
      begin
        cnt_q <= 11'h000;
        fq <= 1'b0;
      end
      else
      begin
        cnt_q <= cnt_d;
        fq <= fd;
      end
    end
    assign flt[g] = fq;
  end
  logic uv_flt;
  logic ov_flt;
  logic oc_flt;
  assign uv_flt = flt[0];
  assign ov_flt = flt[1];
  assign oc_flt = flt[2];

  // ----------------------------------------
  // registers and status flags
  // ----------------------------------------
  hbc_pkg::hbc_reg_sel_t sel;
  logic wr;
  hbc_pkg::hbc_cfg_t cfg_q;
  hbc_pkg::hbc_cfg_t cfg_d;
  logic [12:0] mask_q;
  logic [12:0] mask_d;
  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] flag_d;
  logic [NCH-1:0] clr;
  logic [12:0] status;
  logic [15:0] resp_d;
  assign sel = hbc_pkg::hbc_reg_sel_t'(FRAME_WORD[`HBC_FRM_SEL_HI:`HBC_FRM_SEL_LO]);
  assign wr = FRAME_STB & FRAME_WORD[`HBC_FRM_WR_BIT];
  assign clr = {FRAME_WORD[`HBC_ST_SC2], FRAME_WORD[`HBC_ST_SC1], FRAME_WORD[`HBC_ST_OC],
    FRAME_WORD[`HBC_ST_OV], FRAME_WORD[`HBC_ST_UV]} & {NCH{wr && sel == hbc_pkg::SEL_STATUS}};
  always_comb
  begin
    status = 13'h0000;
    status[`HBC_ST_UV] = flag_q[0];
    status[`HBC_ST_OV] = flag_q[1];
    status[`HBC_ST_OC] = flag_q[2];
    status[`HBC_ST_SC1] = flag_q[3];
    status[`HBC_ST_SC2] = flag_q[4];
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (wr && sel == hbc_pkg::SEL_CFG)
      cfg_d = hbc_pkg::hbc_cfg_t'(FRAME_WORD[12:0]);
    if (wr && sel == hbc_pkg::SEL_MASK)
      mask_d = FRAME_WORD[12:0];
    flag_d = flt | (flag_q & ~(clr & ~flt));
    resp_d = RESP_WORD;
    if (FRAME_STB)
    begin
      case (sel)
        hbc_pkg::SEL_ID: resp_d = {3'h0, ID_VALUE};
        hbc_pkg::SEL_STATUS: resp_d = {1'b0, sel, status};
        hbc_pkg::SEL_MASK: resp_d = {1'b0, sel, mask_q};
        hbc_pkg::SEL_CFG: resp_d = {1'b0, sel, cfg_q};
        default: resp_d = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cfg_q <= `HBC_CFG_RST;
      mask_q <= `HBC_MASK_RST;
      flag_q <= 5'h00;
      RESP_WORD <= 16'h0000;
    end
    else
    begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      flag_q <= flag_d;
      RESP_WORD <= resp_d;
    end
  end

  // ----------------------------------------
  // output steering
  // ----------------------------------------
  logic ctrl_on;
  logic in1;
  logic in2;
  logic o1;
  logic o2;
  logic hb;
  hbc_pkg::hbc_gate_t g1_d;
  hbc_pkg::hbc_gate_t g2_d;
  logic creg_d;
  logic fs_n_d;
  assign hb = cfg_q.hbridge_mode;
  assign ctrl_on = cfg_q.output_enable & wake_s & ~shutoff_s & ~uv_flt;
  assign in1 = cfg_q.input_from_spi ? cfg_q.virtual_input_one : pin1_s;
  assign in2 = cfg_q.input_from_spi ? cfg_q.virtual_input_two : pin2_s;
  always_comb
  begin
    o1 = in1;
    o2 = in2;
    if (hb && !in2)
    begin
      o1 = 1'b1;
      o2 = 1'b1;
    end
    else if (hb)
      o2 = ~in1;
    g1_d = '{hs: o1, ls: ~o1};
    g2_d = '{hs: o2, ls: ~o2};
    if (hb && ov_flt && !mask_q[`HBC_MASK_DOV])
    begin
      g1_d = '{hs: 1'b1, ls: 1'b0};
      g2_d = '{hs: 1'b1, ls: 1'b0};
    end
    if (flag_q[3] || (hb && flag_q[4]))
      g1_d = '{hs: 1'b0, ls: 1'b0};
    if (flag_q[4] || (hb && flag_q[3]))
      g2_d = '{hs: 1'b0, ls: 1'b0};
    if (!ctrl_on)
    begin
      g1_d = '{hs: 1'b0, ls: 1'b0};
      g2_d = '{hs: 1'b0, ls: 1'b0};
    end
    creg_d = ctrl_on & hb & cfg_q.active_limit_select & oc_flt;
    fs_n_d = ~|(status[11:0] & mask_q[11:0]);
  end
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      BRIDGE_OUTPUT_ONE <= '{hs: 1'b0, ls: 1'b0};
      BRIDGE_OUTPUT_TWO <= '{hs: 1'b0, ls: 1'b0};
      CURRENT_REG_ACTIVE <= 1'b0;
      CURRENT_THRESHOLD_SEL <= 2'h0;
      SLEW_SEL <= 3'h0;
      OPEN_LOAD_CHK_EN <= 1'b0;
      FAULT_STATUS_PIN_N <= 1'b1;
    end
    else
    begin
      BRIDGE_OUTPUT_ONE <= g1_d;
      BRIDGE_OUTPUT_TWO <= g2_d;
      CURRENT_REG_ACTIVE <= creg_d;
      CURRENT_THRESHOLD_SEL <= {cfg_q.current_threshold_sel_hi, cfg_q.current_threshold_sel_lo};
      SLEW_SEL <= {cfg_q.slew_sel_b2, cfg_q.slew_sel_b1, cfg_q.slew_sel_b0};
      OPEN_LOAD_CHK_EN <= cfg_q.open_load_chk & hb;
      FAULT_STATUS_PIN_N <= fs_n_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_en_off;
    @(posedge SYS_CLK) disable iff (!RSTN)
    !cfg_q.output_enable |=> BRIDGE_OUTPUT_ONE == 2'b00 && BRIDGE_OUTPUT_TWO == 2'b00;
  endproperty
  a_en_off: assert property (p_en_off) else $error("outputs on while enable clear");
  property p_wake;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (!wake_s || shutoff_s) |=> BRIDGE_OUTPUT_ONE == 2'b00 && BRIDGE_OUTPUT_TWO == 2'b00;
  endproperty
  a_wake: assert property (p_wake) else $error("outputs on without wake");
  property p_uv_off;
    @(posedge SYS_CLK) disable iff (!RSTN)
    uv_flt |=> BRIDGE_OUTPUT_ONE == 2'b00 && BRIDGE_OUTPUT_TWO == 2'b00;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("outputs on in undervoltage");
  property p_ov_filt;
    @(posedge SYS_CLK) disable iff (!RSTN)
    $rose(ov_flt) |-> $past(cmp[1]) && $past(cmp[1], 2);
  endproperty
  a_ov_filt: assert property (p_ov_filt) else $error("overvoltage without persistence");
  property p_ov_brake;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (ctrl_on && hb && ov_flt && !mask_q[`HBC_MASK_DOV] && flag_q[4:3] == 2'b00)
      |=> BRIDGE_OUTPUT_ONE == 2'b10 && BRIDGE_OUTPUT_TWO == 2'b10;
  endproperty
  a_ov_brake: assert property (p_ov_brake) else $error("no brake in overvoltage");
  property p_half_follow;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (ctrl_on && !hb && flag_q[4:3] == 2'b00) |=> BRIDGE_OUTPUT_ONE.hs == $past(in1)
      && BRIDGE_OUTPUT_TWO.hs == $past(in2);
  endproperty
  a_half_follow: assert property (p_half_follow) else $error("half bridge not following");
  property p_no_limit;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (!hb || !cfg_q.active_limit_select) |=> !CURRENT_REG_ACTIVE;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("regulation while disallowed");
  property p_clr_held;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (flt[1] && clr[1]) |=> flag_q[1];
  endproperty
  a_clr_held: assert property (p_clr_held) else $error("flag cleared while fault present");
  property p_ov_sticky;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (flag_q[1] && !clr[1]) |=> flag_q[1];
  endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("overvoltage flag lost");
  property p_status_read;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (FRAME_STB && sel == hbc_pkg::SEL_STATUS) |=> RESP_WORD[9] == $past(flag_q[0])
      && RESP_WORD[8] == $past(flag_q[1]);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word wrong");

endmodule

`default_nettype wire

// ==== hw/hbc_pkg.sv ====
// types of the bridge control block
// assumes hbc_regs.svh for numeric constants
`default_nettype none
package hbc_pkg;

  typedef enum logic [1:0] {
    SEL_ID = 2'b00,
    SEL_STATUS = 2'b01,
    SEL_MASK = 2'b10,
    SEL_CFG = 2'b11
  } hbc_reg_sel_t;

  typedef struct packed {
    logic open_load_chk;
    logic thermal_mgmt;
    logic active_limit_select;
    logic current_threshold_sel_hi;
    logic current_threshold_sel_lo;
    logic slew_sel_b2;
    logic slew_sel_b1;
    logic slew_sel_b0;
    logic output_enable;
    logic hbridge_mode;
    logic input_from_spi;
    logic virtual_input_two;
    logic virtual_input_one;
  } hbc_cfg_t;

  typedef struct packed {
    logic hs;
    logic ls;
  } hbc_gate_t;

endpackage
`default_nettype wire

// ==== hw/hbc_regs.svh ====
// constants of the bridge control block: field positions, resets, timing
// assumes the including file uses them as plain `define values
`ifndef HBC_REGS_SVH
`define HBC_REGS_SVH

// frame layout
`define HBC_FRM_WR_BIT 15
`define HBC_FRM_SEL_HI 14
`define HBC_FRM_SEL_LO 13

// reset values of the writable registers (bits 12:0)
`define HBC_CFG_RST 13'h0d98
`define HBC_MASK_RST 13'h06f1

// status and mask bit positions
`define HBC_ST_UV 9
`define HBC_ST_OV 8
`define HBC_ST_SC2 5
`define HBC_ST_SC1 4
`define HBC_ST_OC 2
`define HBC_MASK_DOV 12

// timing
`define HBC_CLK_NS 8
`define HBC_UV_FILT_NS 10000
`define HBC_OV_FILT_NS 3000
`define HBC_UV_FILT_CYC (`HBC_UV_FILT_NS / `HBC_CLK_NS)
`define HBC_OV_FILT_CYC (`HBC_OV_FILT_NS / `HBC_CLK_NS)
`define HBC_OC_FILT_CYC 4
`define HBC_SC_FILT_CYC 4

`endif

// ==== verification/hbc_host.sv ====
// host model: sends frames and drives the parallel control pins
// assumes tb_top calls its tasks; all changes made on the falling edge
`timescale 1ns/100ps
`default_nettype none
module hbc_host (
  input wire logic clk,
  output logic stb,
  output logic [15:0] word,
  output logic wake,
  output logic shut,
  output logic d1,
  output logic d2
);
  // ----------------
  // frames and pins
  // ----------------
  initial {stb, word, wake, shut, d1, d2} = '0;
  // one word per strobe; writing one to a status bit clears it unless its filtered fault persists
  task automatic frame(input logic [15:0] w);
    @(negedge clk);
    stb = 1'b1;
    word = w;
    @(negedge clk);
    stb = 1'b0;
    word = ~w;
  endtask
  task automatic pins(input logic [3:0] p);
    @(negedge clk);
    {wake, shut, d1, d2} = p;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// bench for the bridge control block: config, steering, supply faults
// assumes hbc_host drives frames and pins; comparators are driven here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int UVF = 8;
  localparam int OVF = 6;
  localparam int FLT = 4;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic lo = 1'b0;
  logic hi = 1'b0;
  logic oc = 1'b0;
  logic [1:0] sc = 2'b00;
  wire logic fs, wake, shut, d1, d2;
  wire logic [15:0] fw;
  logic [15:0] resp;
  hbc_pkg::hbc_gate_t o1, o2;
  logic cra, olc, fpn, stb_d;
  logic [1:0] thr;
  logic [2:0] slew;
  logic [11:0] obs;
  logic [12:0] sh [4];
  logic [15:0] rq [$];
  logic [23:0] oq [$];
  logic [23:0] t;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  assign obs = {cra, olc, fpn, slew, thr, o1, o2};
  hbc_host u_hbc_host (.clk(SYS_CLK), .stb(fs), .word(fw), .wake(wake), .shut(shut), .d1(d1), .d2(d2));
  hbc_ctrl #(.UV_FILT_CYC(UVF), .OV_FILT_CYC(OVF), .OC_FILT_CYC(FLT), .SC_FILT_CYC(FLT)) u_hbc_ctrl (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .FRAME_STB(fs), .FRAME_WORD(fw), .RESP_WORD(resp),
    .WAKE_PIN(wake), .SHUTOFF_PIN(shut), .DRIVE_PIN_ONE(d1), .DRIVE_PIN_TWO(d2),
    .SUPPLY_LOW_CMP(lo), .SUPPLY_HIGH_CMP(hi), .CURRENT_OVER_CMP(oc), .SHORT_CMP(sc),
    .BRIDGE_OUTPUT_ONE(o1), .BRIDGE_OUTPUT_TWO(o2), .CURRENT_REG_ACTIVE(cra),
    .CURRENT_THRESHOLD_SEL(thr), .SLEW_SEL(slew), .OPEN_LOAD_CHK_EN(olc), .FAULT_STATUS_PIN_N(fpn));
  // ----------------
  // checking
  // ----------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge SYS_CLK or negedge RSTN)
    if (!RSTN)
      stb_d <= 1'b0;
    else
      stb_d <= fs;
  always @(negedge SYS_CLK)
  begin
    #2;
    if (stb_d)
      chk(resp, rq.pop_front());
    while (oq.size() > 0)
    begin
      t = oq.pop_front();
      chk({4'h0, obs & t[23:12]}, {4'h0, t[11:0]});
    end
  end
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  // ----------------
  // stimulus helpers
  // ----------------
  task automatic fr(input logic rw, input logic [1:0] s, input logic [12:0] d);
    rq.push_back({1'b0, s, sh[s]});
    if (rw && s > 2'd1)
      sh[s] = d;
    u_hbc_host.frame({rw, s, d});
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic eo(input logic [11:0] m, input logic [11:0] e);
    oq.push_back({m, e});
  endtask
  function automatic logic [3:0] gt(input logic m, input logic i1, input logic i2);
    if (m)
      return i2 ? (i1 ? 4'b1001 : 4'b0110) : 4'b1010;
    return {i1 ? 2'b10 : 2'b01, i2 ? 2'b10 : 2'b01};
  endfunction
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    logic [3:0] k;
    logic [31:0] r;
    sh = '{13'h0000, 13'h0000, 13'h06f1, 13'h0d98};
    void'($urandom(32'hab080051));
    wt(5);
    RSTN = 1'b1;
    wt(1);
    eo(12'h3f0, 12'h310);
    fr(0, 2'd3, 13'h0000);
    for (int i = 0; i < 16; i++)
    begin
      k = 4'(i);
      r = $urandom;
      fr(1, 2'd3, 13'h0d90 | 13'(k));
      u_hbc_host.pins({2'b10, k[2] ? r[1:0] : {k[0], k[1]}});
      wt(4);
      eo(12'h00f, {8'h00, gt(k[3], k[0], k[1])});
    end
    fr(1, 2'd3, 13'h0d98);
    u_hbc_host.pins(4'b1011);
    wt(4);
    eo(12'h00f, 12'h009);
    fr(1, 2'd3, 13'h0d88);
    wt(3);
    eo(12'h00f, 12'h000);
    fr(1, 2'd3, 13'h0d98);
    u_hbc_host.pins(4'b0011);
    wt(4);
    eo(12'h00f, 12'h000);
    u_hbc_host.pins(4'b1111);
    wt(4);
    eo(12'h00f, 12'h000);
    u_hbc_host.pins(4'b1011);
    oc = 1'b1;
    wt(FLT + 5);
    eo(12'h80f, 12'h809);
    fr(1, 2'd3, 13'h0d90);
    wt(3);
    eo(12'h80f, 12'h00a);
    fr(1, 2'd3, 13'h0998);
    wt(3);
    eo(12'h80f, 12'h009);
    sh[1] = 13'h0004;
    fr(0, 2'd1, 13'h0000);
    oc = 1'b0;
    wt(FLT + 5);
    fr(1, 2'd1, 13'h0004);
    sh[1] = 13'h0000;
    fr(1, 2'd3, 13'h0d98);
    lo = 1'b1;
    wt(UVF - 2);
    lo = 1'b0;
    wt(UVF + 5);
    eo(12'h20f, 12'h209);
    lo = 1'b1;
    wt(UVF + 5);
    eo(12'h20f, 12'h000);
    sh[1] = 13'h0200;
    fr(1, 2'd1, 13'h0200);
    fr(0, 2'd1, 13'h0000);
    lo = 1'b0;
    wt(UVF + 5);
    eo(12'h00f, 12'h009);
    fr(1, 2'd1, 13'h0200);
    sh[1] = 13'h0000;
    fr(0, 2'd1, 13'h0000);
    hi = 1'b1;
    wt(OVF + 5);
    eo(12'h00f, 12'h00a);
    sh[1] = 13'h0100;
    hi = 1'b0;
    wt(OVF + 5);
    eo(12'h00f, 12'h009);
    fr(1, 2'd1, 13'h0100);
    sh[1] = 13'h0000;
    fr(1, 2'd2, 13'h16f1);
    hi = 1'b1;
    wt(OVF + 5);
    eo(12'h00f, 12'h009);
    sh[1] = 13'h0100;
    hi = 1'b0;
    wt(OVF + 5);
    fr(1, 2'd1, 13'h0100);
    sh[1] = 13'h0000;
    fr(1, 2'd3, 13'h0d90);
    sc = 2'b01;
    wt(FLT + 7);
    eo(12'h20f, 12'h002);
    sc = 2'b00;
    wt(FLT + 5);
    sh[1] = 13'h0010;
    fr(1, 2'd1, 13'h0010);
    wt(3);
    eo(12'h00f, 12'h00a);
    fr(1, 2'd3, 13'h1e78);
    wt(3);
    eo(12'hfff, 12'h6e9);
    fr(1, 2'd3, 13'h1e70);
    wt(3);
    eo(12'hfff, 12'h2ea);
    fr(0, 2'd0, 13'h0000);
    wt(2);
    give_verdict();
  end
endmodule
`default_nettype wire
